// >>> verilog/sus_pkg.sv
/*
 package for the synthesizer speed-up sequencer: register map, field layout,
 ratio codes and reset values. assumes nothing beyond a sv compiler.
*/
package sus_pkg;
	localparam int          SUS_AW          = 4;
	localparam int          SUS_DW          = 32;
	localparam int          SUS_CW          = 6;
	localparam int          SUS_DURW        = 7;
	// register offsets, byte addresses of aligned words
	localparam logic [3:0]  SUS_A_MAIN_FREQ = 4'h0;
	localparam logic [3:0]  SUS_A_AUX_CFG   = 4'h4;
	localparam logic [3:0]  SUS_A_POWER     = 4'h8;
	localparam logic [3:0]  SUS_A_STROBE    = 4'hC;
	// main frequency word: B[15:5], A[4:0], C[21:16]
	localparam int          SUS_F_FREQ_LSB  = 0;
	localparam int          SUS_F_FREQ_W    = 16;
	localparam int          SUS_F_MCNT_LSB  = 16;
	// aux config word: G[5:0], main ratio[9:8], aux ratio[11:10]
	localparam int          SUS_F_ACNT_LSB  = 0;
	localparam int          SUS_F_MRAT_LSB  = 8;
	localparam int          SUS_F_ARAT_LSB  = 10;
	// power word: main[0], aux1[1], aux2[2]
	localparam int          SUS_F_PWR_MAIN  = 0;
	localparam int          SUS_F_PWR_AUX1  = 1;
	localparam int          SUS_F_PWR_AUX2  = 2;
	localparam int          SUS_F_PWR_W     = 3;
	// strobe register bit 0 is the serial strobe level
	localparam int          SUS_F_STB       = 0;
	localparam logic [31:0] SUS_RST_WORD    = 32'h0000_0000;
	localparam logic [6:0]  SUS_DUR_ZERO    = 7'h00;
	localparam logic [6:0]  SUS_DUR_ONE     = 7'h01;
	// speed-up to normal current ratio codes
	typedef enum logic [1:0] {
		SUS_RATIO_1 = 2'b00,
		SUS_RATIO_2 = 2'b01,
		SUS_RATIO_4 = 2'b10,
		SUS_RATIO_8 = 2'b11
	} sus_ratio_t;
endpackage : sus_pkg

// >>> verilog/sus_sync.sv
/*
 two-flop level synchroniser plus a toggle carried as a level.
 assumes the input level is stable for several destination clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module sus_sync (
	// clock
	input  wire logic dst_clk,
	// data
	input  wire logic src_lvl,
	output var  logic dst_lvl
);
	import sus_pkg::*;
	logic meta_q;
	logic sync_q;
	always_ff @(posedge dst_clk) begin
		meta_q <= src_lvl;
		sync_q <= meta_q;
	end
	assign dst_lvl = sync_q;
endmodule : sus_sync
`default_nettype wire

// >>> verilog/sus_loop_timer.sv
/*
 one loop's speed-up timer, clocked by that loop's phase detector reference.
 a toggle request from ref_clk starts it; assumes pd_rst is a synchronised
 copy of reset in this domain.
*/
`timescale 1ns/1ps
`default_nettype none
module sus_loop_timer (
	// loop reference domain
	input  wire logic                         pd_clk,
	input  wire logic                         pd_rst,
	// request from control domain
	input  wire logic                         req_tgl,
	input  wire logic [sus_pkg::SUS_CW-1:0]   count,
	// speed-up state
	output var  logic                         boost
);
	import sus_pkg::*;
	logic                req_s;
	logic                req_seen_q;
	logic [SUS_DURW-1:0] cnt_q;
	logic [SUS_DURW-1:0] cnt_d;
	wire                 start = req_s ^ req_seen_q;

	sus_sync u_req (
		.dst_clk (pd_clk),
		.src_lvl (req_tgl),
		.dst_lvl (req_s)
	);

	// duration is twice the count in reference periods
	assign cnt_d = start ? {count, 1'b0} :
		(cnt_q != SUS_DUR_ZERO) ? cnt_q - SUS_DUR_ONE : cnt_q;

	always_ff @(posedge pd_clk) begin
		if (pd_rst) begin
			req_seen_q <= 1'b0;
			cnt_q      <= SUS_DUR_ZERO;
		end else begin
			req_seen_q <= req_s;
			cnt_q      <= cnt_d;
		end
	end
	// boost and low-impedance switch until terminal count
	assign boost = (cnt_q != SUS_DUR_ZERO);

	AST_TIMER_LOAD: assert property (@(posedge pd_clk) disable iff (pd_rst)
		start |=> cnt_q == {$past(count), 1'b0})
		else $error("timer did not load twice the count");
	AST_TIMER_DOWN: assert property (@(posedge pd_clk) disable iff (pd_rst)
		(!start && cnt_q != SUS_DUR_ZERO) |=> cnt_q == $past(cnt_q) - SUS_DUR_ONE)
		else $error("timer did not count down by one");
	AST_TIMER_HOLD: assert property (@(posedge pd_clk) disable iff (pd_rst)
		(!start && cnt_q == SUS_DUR_ZERO) |=> !boost)
		else $error("boost left on after terminal count");
endmodule : sus_loop_timer
`default_nettype wire

// >>> verilog/sus_sequencer.sv
/*
 speed-up sequencer for a three-loop synthesizer: register port, strobe
 edge detect, reference-pulse synchronised loads and three speed-up timers.
 assumes ref_pulse is a one-cycle pulse on ref_clk and each pd clock is
 free running.
*/
// Operation
// - strobe edge loads main frequency at reference pulse
// - main load of a changed frequency starts switch low-impedance and boost
// - speed-up holds while main counter non-zero
// - main counter clocked only by main reference
// - main terminal count ends switch and boost
// - auxiliary speed-up only on enable zero-to-one
// - strobe edge latches power word at reference pulse
// - newly enabled aux loop starts boost and switch
// - aux holds until own counter reaches zero
// - aux terminal count ends boost and switch
// - ratio codes select one, two, four, eight
// - shared aux count, separate aux counters
// - duration is twice count reference periods
// - section powered only while enable bit one
`timescale 1ns/1ps
`default_nettype none
module sus_sequencer (
	// control clock and reset
	input  wire logic                          ref_clk,
	input  wire logic                          reset,
	// reference pulse from the reference divider
	input  wire logic                          ref_pulse,
	// loop phase detector reference clocks
	input  wire logic                          main_pd_clk,
	input  wire logic                          aux1_pd_clk,
	input  wire logic                          aux2_pd_clk,
	// register port
	input  wire logic [sus_pkg::SUS_AW-1:0]    addr,
	input  wire logic [sus_pkg::SUS_DW-1:0]    wdata,
	input  wire logic                          wr_stb,
	input  wire logic                          rd_stb,
	output var  logic [sus_pkg::SUS_DW-1:0]    rdata,
	// loaded main frequency to the prescaler
	output var  logic [sus_pkg::SUS_F_FREQ_W-1:0] main_freq,
	// section power enables
	output var  logic                          main_pwr_en,
	output var  logic                          aux1_pwr_en,
	output var  logic                          aux2_pwr_en,
	// speed-up switches, high means low impedance
	output var  logic                          main_sw_on,
	output var  logic                          aux1_sw_on,
	output var  logic                          aux2_sw_on,
	// boost charge pumps
	output var  logic                          main_boost,
	output var  logic                          aux1_boost,
	output var  logic                          aux2_boost,
	// current ratio selects
	output var  sus_pkg::sus_ratio_t           main_ratio,
	output var  sus_pkg::sus_ratio_t           aux_ratio
);
	import sus_pkg::*;

	logic [SUS_DW-1:0]       freq_q;
	logic [SUS_DW-1:0]       cfg_q;
	logic [SUS_F_PWR_W-1:0]  pwr_sh_q;
	logic                    stb_q;
	logic                    stb_prev_q;
	logic                    load_pend_q;
	logic [SUS_F_FREQ_W-1:0] main_freq_q;
	logic [SUS_F_PWR_W-1:0]  pwr_q;
	// counts snapshotted at the load, so they are stable while a toggle crosses
	logic [SUS_CW-1:0]       main_cnt_q;
	logic [SUS_CW-1:0]       aux_cnt_q;
	logic                    main_tgl_q;
	logic                    aux1_tgl_q;
	logic                    aux2_tgl_q;
	logic [SUS_DW-1:0]       rdata_q;
	logic [2:0]              boost_s;
	logic [2:0]              boost_q;
	logic [1:0]              rst_m_q;
	logic [1:0]              rst_a1_q;
	logic [1:0]              rst_a2_q;

	// register decode
	wire wr_freq  = wr_stb && addr == SUS_A_MAIN_FREQ;
	wire wr_cfg   = wr_stb && addr == SUS_A_AUX_CFG;
	wire wr_pwr   = wr_stb && addr == SUS_A_POWER;
	wire wr_stbr  = wr_stb && addr == SUS_A_STROBE;
	wire stb_rise = stb_q && !stb_prev_q;
	// strobe edge arms one load, done on next reference pulse
	wire do_load  = load_pend_q && ref_pulse;
	wire [SUS_CW-1:0] main_cnt = freq_q[SUS_F_MCNT_LSB +: SUS_CW];
	wire [SUS_CW-1:0] aux_cnt  = cfg_q[SUS_F_ACNT_LSB +: SUS_CW];
	// a new frequency is only taken from the shadow after the strobe
	wire [SUS_F_FREQ_W-1:0] freq_new = freq_q[SUS_F_FREQ_LSB +: SUS_F_FREQ_W];
	wire main_chg = do_load && freq_new != main_freq_q;
	wire aux1_up  = do_load && pwr_sh_q[SUS_F_PWR_AUX1]
		&& !pwr_q[SUS_F_PWR_AUX1];
	wire aux2_up  = do_load && pwr_sh_q[SUS_F_PWR_AUX2]
		&& !pwr_q[SUS_F_PWR_AUX2];
	wire unused_ok = (addr[1:0] == 2'b00);
	logic [SUS_DW-1:0] rd_mux;
	always_comb begin
		rd_mux = SUS_RST_WORD;
		if (unused_ok) begin
			case (addr)
				SUS_A_MAIN_FREQ: rd_mux = freq_q;
				SUS_A_AUX_CFG:   rd_mux = cfg_q;
				SUS_A_POWER:     rd_mux = {{(SUS_DW-SUS_F_PWR_W){1'b0}}, boost_q};
				SUS_A_STROBE:    rd_mux = {{(SUS_DW-1){1'b0}}, stb_q};
				default:         rd_mux = SUS_RST_WORD;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			freq_q   <= SUS_RST_WORD;
			cfg_q    <= SUS_RST_WORD;
			pwr_sh_q <= '0;
			stb_q    <= 1'b0;
			rdata_q  <= SUS_RST_WORD;
		end else begin
			if (wr_freq) freq_q <= wdata;
			if (wr_cfg)  cfg_q  <= wdata;
			if (wr_pwr)  pwr_sh_q <= wdata[SUS_F_PWR_W-1:0];
			if (wr_stbr) stb_q  <= wdata[SUS_F_STB];
			rdata_q <= rd_stb ? rd_mux : SUS_RST_WORD;
		end
	end

	// a new strobe edge during a pending load simply stays pending
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			stb_prev_q  <= 1'b0;
			load_pend_q <= 1'b0;
		end else begin
			stb_prev_q  <= stb_q;
			load_pend_q <= stb_rise || (load_pend_q && !ref_pulse);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			main_freq_q <= '0;
			main_cnt_q  <= '0;
			aux_cnt_q   <= '0;
			pwr_q       <= '0;
			main_tgl_q  <= 1'b0;
			aux1_tgl_q  <= 1'b0;
			aux2_tgl_q  <= 1'b0;
		end else begin
			if (do_load) begin
				main_freq_q <= freq_new;
				main_cnt_q  <= main_cnt;
				aux_cnt_q   <= aux_cnt;
				pwr_q       <= pwr_sh_q;
			end
			// toggles cross into each loop's reference domain
			if (main_chg) main_tgl_q <= !main_tgl_q;
			if (aux1_up)  aux1_tgl_q <= !aux1_tgl_q;
			if (aux2_up)  aux2_tgl_q <= !aux2_tgl_q;
		end
	end

	// reset into each loop domain through two flops
	always_ff @(posedge main_pd_clk) rst_m_q  <= {rst_m_q[0], reset};
	always_ff @(posedge aux1_pd_clk) rst_a1_q <= {rst_a1_q[0], reset};
	always_ff @(posedge aux2_pd_clk) rst_a2_q <= {rst_a2_q[0], reset};

	logic main_b;
	logic aux1_b;
	logic aux2_b;
	sus_loop_timer u_main (
		.pd_clk  (main_pd_clk),
		.pd_rst  (rst_m_q[1]),
		.req_tgl (main_tgl_q),
		.count   (main_cnt_q),
		.boost   (main_b)
	);
	sus_loop_timer u_aux1 (
		.pd_clk  (aux1_pd_clk),
		.pd_rst  (rst_a1_q[1]),
		.req_tgl (aux1_tgl_q),
		.count   (aux_cnt_q),
		.boost   (aux1_b)
	);
	sus_loop_timer u_aux2 (
		.pd_clk  (aux2_pd_clk),
		.pd_rst  (rst_a2_q[1]),
		.req_tgl (aux2_tgl_q),
		.count   (aux_cnt_q),
		.boost   (aux2_b)
	);

	// boost levels back into ref_clk, costs a few cycles of latency
	sus_sync u_bm  (.dst_clk(ref_clk), .src_lvl(main_b), .dst_lvl(boost_s[0]));
	sus_sync u_ba1 (.dst_clk(ref_clk), .src_lvl(aux1_b), .dst_lvl(boost_s[1]));
	sus_sync u_ba2 (.dst_clk(ref_clk), .src_lvl(aux2_b), .dst_lvl(boost_s[2]));

	always_ff @(posedge ref_clk) begin
		if (reset) boost_q <= '0;
		else       boost_q <= boost_s & pwr_q;
	end

	assign rdata       = rdata_q;
	assign main_freq   = main_freq_q;
	assign main_pwr_en = pwr_q[SUS_F_PWR_MAIN];
	assign aux1_pwr_en = pwr_q[SUS_F_PWR_AUX1];
	assign aux2_pwr_en = pwr_q[SUS_F_PWR_AUX2];
	assign main_sw_on  = boost_q[0];
	assign aux1_sw_on  = boost_q[1];
	assign aux2_sw_on  = boost_q[2];
	assign main_boost  = boost_q[0];
	assign aux1_boost  = boost_q[1];
	assign aux2_boost  = boost_q[2];
	// ratio code passes straight to the pump scaler
	assign main_ratio  = sus_ratio_t'(cfg_q[SUS_F_MRAT_LSB +: 2]);
	assign aux_ratio   = sus_ratio_t'(cfg_q[SUS_F_ARAT_LSB +: 2]);

	AST_LOAD_AT_PULSE: assert property (@(posedge ref_clk) disable iff (reset)
		do_load |=> main_freq_q == $past(freq_new))
		else $error("main frequency not loaded at reference pulse");
	AST_NO_EARLY_LOAD: assert property (@(posedge ref_clk) disable iff (reset)
		(!load_pend_q) |=> main_freq_q == $past(main_freq_q))
		else $error("main frequency changed without strobe");
	AST_PWR_LATCH: assert property (@(posedge ref_clk) disable iff (reset)
		do_load |=> pwr_q == $past(pwr_sh_q))
		else $error("power word not latched");
	AST_AUX_RISE_ONLY: assert property (@(posedge ref_clk) disable iff (reset)
		(do_load && !aux1_up) |=> aux1_tgl_q == $past(aux1_tgl_q))
		else $error("aux1 speed-up without enable rise");
	AST_MAIN_TRIGGER: assert property (@(posedge ref_clk) disable iff (reset)
		main_chg |=> main_tgl_q != $past(main_tgl_q))
		else $error("main speed-up not requested");
	AST_AUX_TRIGGER: assert property (@(posedge ref_clk) disable iff (reset)
		aux2_up |=> aux2_tgl_q != $past(aux2_tgl_q))
		else $error("aux2 speed-up not requested");
	AST_PWR_GATE: assert property (@(posedge ref_clk) disable iff (reset)
		!aux1_pwr_en |=> !aux1_boost)
		else $error("boost on in a powered-down section");
	AST_RATIO_MAP: assert property (@(posedge ref_clk) disable iff (reset)
		main_ratio == cfg_q[SUS_F_MRAT_LSB +: 2])
		else $error("main ratio code mismatch");
	AST_SW_BOOST: assert property (@(posedge ref_clk) disable iff (reset)
		aux2_sw_on == aux2_boost && main_sw_on == main_boost)
		else $error("switch and boost disagree");
endmodule : sus_sequencer
`default_nettype wire

// >>> test/sus_host.sv
/*
 host model: drives the register port of the sequencer.
 assumes ref_clk is the port clock and no wait states.
*/
`timescale 1ns/1ps
`default_nettype none
module sus_host (
	// clock
	input  wire logic        clk,
	// register port
	output var  logic [3:0]  addr,
	output var  logic [31:0] wdata,
	output var  logic        wr_stb,
	output var  logic        rd_stb,
	input  wire logic [31:0] rdata
);
	initial begin
		addr = 4'h0;
		wdata = 32'h0000_0000;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
	end
	// words are always written before the strobe bit
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask : wr
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask : rd
endmodule : sus_host
`default_nettype wire

// >>> test/sus_sequencer_bench.sv
/*
 bench for the speed-up sequencer: random loads, ratio codes, timed boosts.
 assumes the register host model and free running pd clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module sus_sequencer_bench;
	import sus_pkg::*;
	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic        ref_pulse = 1'b0;
	logic        main_pd_clk = 1'b0;
	logic        aux1_pd_clk = 1'b0;
	logic        aux2_pd_clk = 1'b0;
	logic [2:0]  pcnt = 3'h0;
	logic [3:0]  addr;
	logic [31:0] wdata, rdata, rv, seed = 32'ha7dc_f414;
	logic        wr_stb, rd_stb;
	logic [15:0] main_freq, f;
	wire  logic [2:0] pwr, sws, boosts;
	sus_ratio_t  main_ratio, aux_ratio;
	int          failures = 0, compares = 0, c, g;
	always #50 ref_clk = ~ref_clk;
	always #6 main_pd_clk = ~main_pd_clk;
	initial begin #3.7; forever #6 aux1_pd_clk = ~aux1_pd_clk; end
	initial begin #8.3; forever #6 aux2_pd_clk = ~aux2_pd_clk; end
	// reference pulse every eight cycles
	always @(posedge ref_clk) begin
		pcnt <= pcnt + 3'h1;
		ref_pulse <= (pcnt == 3'h7) && !reset;
	end
	sus_host sus_host_inst (.clk(ref_clk), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .rdata(rdata));
	sus_sequencer sus_sequencer_inst (.ref_clk(ref_clk), .reset(reset), .ref_pulse(ref_pulse),
		.main_pd_clk(main_pd_clk), .aux1_pd_clk(aux1_pd_clk), .aux2_pd_clk(aux2_pd_clk),
		.addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
		.main_freq(main_freq), .main_pwr_en(pwr[0]), .aux1_pwr_en(pwr[1]),
		.aux2_pwr_en(pwr[2]), .main_sw_on(sws[0]), .aux1_sw_on(sws[1]), .aux2_sw_on(sws[2]),
		.main_boost(boosts[0]), .aux1_boost(boosts[1]), .aux2_boost(boosts[2]),
		.main_ratio(main_ratio), .aux_ratio(aux_ratio));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	// boost length in ref_clk cycles: two pd periods of 12 ns per count
	function automatic int exp_cyc(input int n);
		return (24 * n) / 100;
	endfunction : exp_cyc
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// strobe right after a pulse so the load lands at the next pulse, eight cycles later
	task automatic load(input logic [15:0] old_f, input logic [15:0] new_f);
		@(negedge ref_clk);
		while (ref_pulse !== 1'b1) @(negedge ref_clk);
		sus_host_inst.wr(SUS_A_STROBE, 32'h0000_0000);
		sus_host_inst.wr(SUS_A_STROBE, 32'h0000_0001);
		@(negedge ref_clk);
		while (ref_pulse !== 1'b1) begin
			chk("freq before pulse", old_f, main_freq);
			@(negedge ref_clk);
		end
		@(negedge ref_clk);
		chk("freq after pulse", new_f, main_freq);
	endtask : load
	// speed-up either absent or of the programmed length, switch tracking boost
	task automatic measure(input int i, input int n, input logic want);
		int w;
		int k;
		w = 0;
		k = 0;
		while (boosts[i] !== 1'b1 && w < 60) begin @(negedge ref_clk); w++; end
		chk("boost start", want, boosts[i] === 1'b1);
		while (boosts[i] === 1'b1 && k < 200) begin
			chk("switch", 1'b1, sws[i]);
			@(negedge ref_clk);
			k++;
		end
		if (want) chk("boost cycles", 1, k >= exp_cyc(n) - 3 && k <= exp_cyc(n) + 3);
		chk("switch off", 1'b0, sws[i]);
	endtask : measure
	task automatic conclude();
		$display("comparisons %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : conclude
	initial begin
		#1_000_000;
		failures++;
		conclude();
	end
	initial begin
		repeat (8) @(posedge ref_clk);
		reset <= 1'b0;
		@(negedge ref_clk);
		chk("idle outputs", 0, {main_freq, pwr, sws, boosts, main_ratio, aux_ratio});
		for (int k = 0; k < 4; k++) begin
			sus_host_inst.wr(SUS_A_AUX_CFG, {20'h0_0000, 2'(3 - k), 2'(k), 8'h00});
			@(negedge ref_clk);
			chk("ratios", {2'(k), 2'(3 - k)}, {main_ratio, aux_ratio});
		end
		sus_host_inst.wr(4'h2, 32'hFFFF_FFFF);
		sus_host_inst.rd(4'h2, rv);
		chk("unmapped read", 32'h0000_0000, rv);
		seed = xs(seed);
		g = 40 + int'(seed[4:0] % 24);
		sus_host_inst.wr(SUS_A_AUX_CFG, 32'(g));
		sus_host_inst.rd(SUS_A_AUX_CFG, rv);
		chk("config read", 32'(g), rv);
		sus_host_inst.wr(SUS_A_POWER, 32'h0000_0001);
		load(16'h0000, 16'h0000);
		chk("power", 3'b001, pwr);
		measure(0, 0, 1'b0);
		f = 16'h0000;
		for (int k = 0; k < 4; k++) begin
			seed = xs(seed);
			c = 40 + int'(seed[20:16] % 24);
			// odd mask, so every new word differs from the loaded one
			sus_host_inst.wr(SUS_A_MAIN_FREQ, {10'h000, 6'(c), (seed[15:0] | 16'h0001) ^ f});
			load(f, (seed[15:0] | 16'h0001) ^ f);
			f = (seed[15:0] | 16'h0001) ^ f;
			measure(0, c, 1'b1);
		end
		sus_host_inst.rd(SUS_A_MAIN_FREQ, rv);
		chk("freq read", {10'h000, 6'(c), f}, rv);
		sus_host_inst.rd(SUS_A_STROBE, rv);
		chk("strobe read", 32'h0000_0001, rv);
		sus_host_inst.rd(SUS_A_POWER, rv);
		chk("boost read", 32'h0000_0000, rv);
		load(f, f);
		measure(0, 0, 1'b0);
		sus_host_inst.wr(SUS_A_POWER, 32'h0000_0003);
		load(f, f);
		measure(1, g, 1'b1);
		sus_host_inst.wr(SUS_A_POWER, 32'h0000_0007);
		load(f, f);
		measure(2, g, 1'b1);
		chk("aux1 quiet", 1'b0, boosts[1]);
		load(f, f);
		measure(1, 0, 1'b0);
		sus_host_inst.wr(SUS_A_POWER, 32'h0000_0001);
		load(f, f);
		chk("power off", 3'b001, pwr);
		sus_host_inst.wr(SUS_A_POWER, 32'h0000_0007);
		load(f, f);
		measure(1, g, 1'b1);
		repeat (4) @(negedge ref_clk);
		chk("aux2 done", 1'b0, boosts[2]);
		conclude();
	end
endmodule : sus_sequencer_bench
`default_nettype wire
